// ### acg_top.sv
`timescale 1ns/1ps
module acg_top (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    input wire logic i_core_xbus_req,
    input wire logic i_core_xbus_internal,
    input wire logic i_core_xsp_req,
    input wire logic i_extended_data_ram_int_en,
    input wire logic i_capture_dest_ext,
    input wire logic i_capture_done,
    input wire logic [13:0] i_cal_result,
    output logic o_ext_port_grant,
    output logic o_int_extended_data_ram_grant,
    output logic o_xsp_grant,
    output logic o_conv_irq,
    output logic o_capture_en,
    output logic o_ext_ref_en,
    output logic [3:0] o_channel_sel,
    output logic [13:0] o_offset_coef,
    output logic [13:0] o_gain_coef,
    output logic o_cal_busy,
    output logic o_cal_is_device
);
    import acg_pkg::*;

    logic [7:0] ctl1_q;
    logic [7:0] ctl2_q;
    logic [1:0] avg_code_q;
    logic cal_type_q;
    logic [13:0] ofs_q;
    logic [13:0] gain_q;
    logic irq_flag_q;
    acg_state_t state_q;
    logic [15:0] ticks_left_q;
    logic tick;
    logic cal_start;
    logic cal_end;
    logic [5:0] averaging_count;
    logic [15:0] acq_clks;
    logic [15:0] cal_ticks;
    logic wr_ctl1;
    logic wr_ctl2;
    logic wr_cal;

    ////////////////////////////////////////////////////////////////////////
    // Write decode
    assign wr_ctl1 = i_sfr_wr && (i_sfr_addr == ADDR_CONTROL_ONE);
    assign wr_ctl2 = i_sfr_wr && (i_sfr_addr == ADDR_CONTROL_TWO);
    assign wr_cal = i_sfr_wr && (i_sfr_addr == ADDR_CAL_CONTROL);
    // A start while busy is ignored so a running cycle keeps its timing
    assign cal_start = wr_cal && i_sfr_wdata[CAL_START_BIT] && (state_q == ACG_IDLE);
    assign cal_end = (state_q == ACG_CAL) && tick && (ticks_left_q == 16'h0001);

    // Converter clock from the core clock
    acg_clk_div u_div (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_ratio(ctl1_q[CLK_DIV_LSB +: 2]),
        .o_tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Converter control one: external reference, divider, acquisition
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctl1_q <= CONTROL_ONE_RST;
        end else if (wr_ctl1) begin
            ctl1_q <= i_sfr_wdata;
        end
    end

    // Converter control two: capture enable and channel select
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctl2_q <= CONTROL_TWO_RST;
        end else if (wr_ctl2) begin
            ctl2_q <= i_sfr_wdata;
        end
    end

    // Interrupt flag; a completion in the clearing cycle still sets it
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_flag_q <= 1'b0;
        end else if (i_capture_done) begin
            irq_flag_q <= 1'b1;
        end else if (wr_ctl2) begin
            irq_flag_q <= i_sfr_wdata[IRQ_FLAG_BIT];
        end
    end

    // Calibration settings latched at start
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            avg_code_q <= CAL_CONTROL_RST[AVG_LSB +: 2];
            cal_type_q <= CAL_CONTROL_RST[CAL_TYPE_BIT];
        end else if (cal_start) begin
            avg_code_q <= i_sfr_wdata[AVG_LSB +: 2];
            cal_type_q <= i_sfr_wdata[CAL_TYPE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cycle length in converter clocks
    always_comb begin
        unique case (avg_code_q)
            2'd0: averaging_count = AVG_CODE0;
            2'd1: averaging_count = AVG_CODE1;
            2'd2: averaging_count = AVG_CODE2;
            2'd3: averaging_count = AVG_CODE3;
        endcase
    end
    assign acq_clks = {14'h0000, ctl1_q[ACQ_LSB +: 2]} + 16'h0001;
    // Widest case is 17640 clocks, inside 16 bits
    assign cal_ticks = 16'(CAL_MULT * {10'h000, averaging_count} * (CAL_BASE_CLKS + acq_clks));

    // Averaging code is latched from the start write, so the count is loaded one cycle later
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= ACG_IDLE;
            ticks_left_q <= 16'h0000;
        end else begin
            unique case (state_q)
                ACG_IDLE: begin
                    if (cal_start) begin
                        state_q <= ACG_CAL;
                        ticks_left_q <= 16'h0000;
                    end
                end
                ACG_CAL: begin
                    if (ticks_left_q == 16'h0000) begin
                        ticks_left_q <= cal_ticks;
                    end else if (cal_end) begin
                        state_q <= ACG_IDLE;
                    end else if (tick) begin
                        ticks_left_q <= ticks_left_q - 16'h0001;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Correction words; calibration result lands in the matching word
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ofs_q <= OFS_RST;
            gain_q <= GAIN_RST;
        end else begin
            if (cal_end && !cal_type_q) begin
                ofs_q <= i_cal_result;
            end else if (i_sfr_wr && i_sfr_addr == ADDR_OFS_LOW) begin
                ofs_q[7:0] <= i_sfr_wdata;
            end else if (i_sfr_wr && i_sfr_addr == ADDR_OFS_HIGH) begin
                ofs_q[13:8] <= i_sfr_wdata[5:0];
            end
            if (cal_end && cal_type_q) begin
                gain_q <= i_cal_result;
            end else if (i_sfr_wr && i_sfr_addr == ADDR_GAIN_LOW) begin
                gain_q[7:0] <= i_sfr_wdata;
            end else if (i_sfr_wr && i_sfr_addr == ADDR_GAIN_HIGH) begin
                gain_q[13:8] <= i_sfr_wdata[5:0];
            end
        end
    end

    // Read data, registered; unmapped addresses read zero
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_sfr_rdata <= 8'h00;
        end else if (i_sfr_rd) begin
            unique case (i_sfr_addr)
                ADDR_CONTROL_ONE: o_sfr_rdata <= ctl1_q;
                ADDR_CONTROL_TWO: o_sfr_rdata <= {irq_flag_q, ctl2_q[6:0]};
                ADDR_CAL_CONTROL: o_sfr_rdata <= {(state_q == ACG_CAL), 1'b0, avg_code_q,
                                                  2'b00, cal_type_q, 1'b0};
                ADDR_OFS_LOW: o_sfr_rdata <= ofs_q[7:0];
                ADDR_OFS_HIGH: o_sfr_rdata <= {2'b00, ofs_q[13:8]};
                ADDR_GAIN_LOW: o_sfr_rdata <= gain_q[7:0];
                ADDR_GAIN_HIGH: o_sfr_rdata <= {2'b00, gain_q[13:8]};
                default: o_sfr_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core access gating; the core still runs the instruction, only the grant drops
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_ext_port_grant <= 1'b0;
            o_int_extended_data_ram_grant <= 1'b0;
            o_xsp_grant <= 1'b0;
        end else begin
            o_ext_port_grant <= i_core_xbus_req && !(i_core_xbus_internal && i_extended_data_ram_int_en)
                                && !ctl2_q[CAPTURE_BIT];
            o_int_extended_data_ram_grant <= i_core_xbus_req && i_core_xbus_internal && i_extended_data_ram_int_en
                                && (!ctl2_q[CAPTURE_BIT] || i_capture_dest_ext);
            o_xsp_grant <= i_core_xsp_req && i_extended_data_ram_int_en
                           && (!ctl2_q[CAPTURE_BIT] || i_capture_dest_ext);
        end
    end

    // Status and control outputs to the converter datapath
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_conv_irq <= 1'b0;
            o_capture_en <= 1'b0;
            o_ext_ref_en <= 1'b0;
            o_channel_sel <= 4'h0;
            o_offset_coef <= OFS_RST;
            o_gain_coef <= GAIN_RST;
            o_cal_busy <= 1'b0;
            o_cal_is_device <= 1'b0;
        end else begin
            o_conv_irq <= irq_flag_q;
            o_capture_en <= ctl2_q[CAPTURE_BIT];
            o_ext_ref_en <= ctl1_q[EXT_REF_BIT];
            o_channel_sel <= ctl2_q[CHAN_LSB +: 4];
            // Datapath subtracts offset, so a larger word lowers the code
            o_offset_coef <= ofs_q;
            // Datapath multiplies by gain, so a larger word steepens the slope
            o_gain_coef <= gain_q;
            o_cal_busy <= (state_q == ACG_CAL);
            o_cal_is_device <= (state_q == ACG_CAL)
                               && (ctl2_q[CHAN_LSB +: 4] == (cal_type_q ? CHAN_INT_REF : CHAN_INT_GND));
        end
    end
endmodule

// ### acg_pkg.sv
package acg_pkg;
    // Special function register addresses
    localparam logic [7:0] ADDR_CONTROL_ONE = 8'hEF;
    localparam logic [7:0] ADDR_CONTROL_TWO = 8'hD8;
    localparam logic [7:0] ADDR_CAL_CONTROL = 8'hF5;
    localparam logic [7:0] ADDR_OFS_LOW = 8'hF1;
    localparam logic [7:0] ADDR_OFS_HIGH = 8'hF2;
    localparam logic [7:0] ADDR_GAIN_LOW = 8'hF3;
    localparam logic [7:0] ADDR_GAIN_HIGH = 8'hF4;

    // converter_control_one fields
    localparam int EXT_REF_BIT = 6;
    localparam int CLK_DIV_LSB = 4;
    localparam int ACQ_LSB = 2;
    // converter_control_two fields
    localparam int IRQ_FLAG_BIT = 7;
    localparam int CAPTURE_BIT = 6;
    localparam int CHAN_LSB = 0;
    // calibration_control fields
    localparam int BUSY_BIT = 7;
    localparam int AVG_LSB = 4;
    localparam int CAL_TYPE_BIT = 1;
    localparam int CAL_START_BIT = 0;

    // Reset values
    localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
    localparam logic [7:0] CONTROL_TWO_RST = 8'h00;
    localparam logic [7:0] CAL_CONTROL_RST = 8'h00;
    localparam logic [13:0] OFS_RST = 14'h2000;
    localparam logic [13:0] GAIN_RST = 14'h2000;

    // Device calibration channel codes
    localparam logic [3:0] CHAN_INT_GND = 4'hB;
    localparam logic [3:0] CHAN_INT_REF = 4'hC;

    // Calibration cycle timing, in converter clocks
    localparam logic [15:0] CAL_MULT = 16'h000E;
    localparam logic [15:0] CAL_BASE_CLKS = 16'h0010;

    // Converter clock divide codes
    localparam logic [3:0] DIV_CODE0 = 4'hF;
    localparam logic [3:0] DIV_CODE1 = 4'h1;
    localparam logic [3:0] DIV_CODE2 = 4'h3;
    localparam logic [3:0] DIV_CODE3 = 4'h7;

    // Averaging counts per averaging code
    localparam logic [5:0] AVG_CODE0 = 6'h0F;
    localparam logic [5:0] AVG_CODE1 = 6'h01;
    localparam logic [5:0] AVG_CODE2 = 6'h1F;
    localparam logic [5:0] AVG_CODE3 = 6'h3F;

    typedef enum logic {
        ACG_IDLE,
        ACG_CAL
    } acg_state_t;
endpackage

// ### acg_clk_div.sv
`timescale 1ns/1ps
module acg_clk_div (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [1:0] i_ratio,
    output logic o_tick
);
    import acg_pkg::*;

    logic [3:0] cnt_q;
    logic [3:0] limit;

    ////////////////////////////////////////////////////////////////////////
    // Divide code to terminal count
    always_comb begin
        unique case (i_ratio)
            2'd0: limit = DIV_CODE0;
            2'd1: limit = DIV_CODE1;
            2'd2: limit = DIV_CODE2;
            2'd3: limit = DIV_CODE3;
        endcase
    end

    // Free-running counter; one tick per converter clock period
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q <= 4'h0;
            o_tick <= 1'b0;
        end else if (cnt_q >= limit) begin
            cnt_q <= 4'h0;
            o_tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            o_tick <= 1'b0;
        end
    end
endmodule

// ### acg_top_assertions.sv
`timescale 1ns/1ps
module acg_chk
    import acg_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_core_xbus_req,
    input wire logic i_core_xbus_internal,
    input wire logic i_core_xsp_req,
    input wire logic i_extended_data_ram_int_en,
    input wire logic i_capture_dest_ext,
    input wire logic i_capture_done,
    input wire logic i_sfr_wr,
    input wire logic [13:0] i_cal_result,
    input wire logic o_ext_port_grant,
    input wire logic o_int_extended_data_ram_grant,
    input wire logic o_xsp_grant,
    input wire logic o_conv_irq,
    input wire logic o_capture_en,
    input wire logic [3:0] o_channel_sel,
    input wire logic [13:0] o_offset_coef,
    input wire logic [13:0] o_gain_coef,
    input wire logic o_cal_busy,
    input wire logic o_cal_is_device
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    logic [11:0] busy_cnt_q;
    ////////////////////////////////////////////////////////////////////////////////
    // Busy length counter, saturating so a long cycle cannot wrap into a false failure
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) busy_cnt_q <= '0;
        else if (!o_cal_busy) busy_cnt_q <= '0;
        else if (busy_cnt_q != 12'hFFF) busy_cnt_q <= busy_cnt_q + 12'h001;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Write guard: capture output lags its register bit by one cycle
    a_ext_port_gate: assert property (i_core_xbus_req && o_capture_en && !$past(i_sfr_wr) |=> !o_ext_port_grant)
        else $error("external port granted during capture");
    a_ext_port_pass: assert property (i_core_xbus_req && !i_core_xbus_internal && !o_capture_en
        && !$past(i_sfr_wr) |=> o_ext_port_grant) else $error("external port refused outside capture");
    a_int_ram_gate: assert property (i_core_xbus_req && i_core_xbus_internal && !i_extended_data_ram_int_en |=> !o_int_extended_data_ram_grant)
        else $error("internal ram granted while disabled");
    a_xsp_pass: assert property (i_core_xsp_req && i_extended_data_ram_int_en && i_capture_dest_ext |=> o_xsp_grant)
        else $error("stack access refused");
    a_xsp_gate: assert property (i_core_xsp_req && o_capture_en && !i_capture_dest_ext && !$past(i_sfr_wr)
        |=> !o_xsp_grant) else $error("stack access granted during internal capture");
    a_irq_on_done: assert property (i_capture_done |-> ##2 o_conv_irq)
        else $error("interrupt missing after capture done");
    a_busy_whole_cycle: assert property ($fell(o_cal_busy) |-> busy_cnt_q >= 12'h1D0)
        else $error("busy dropped too early");
    a_cal_word_stored: assert property ($fell(o_cal_busy) |-> o_offset_coef == i_cal_result
        || o_gain_coef == i_cal_result) else $error("calibration result not stored");
    a_device_channel: assert property (o_cal_is_device && $stable(o_channel_sel)
        |-> o_channel_sel == CHAN_INT_GND || o_channel_sel == CHAN_INT_REF)
        else $error("device mode on wrong channel");
    c_cal_end: cover property ($fell(o_cal_busy));
    c_capture_done: cover property (i_capture_done);
    c_ext_blocked: cover property (i_core_xbus_req && o_capture_en);
endmodule

// ### acg_top_bench.sv
`timescale 1ns/1ps
module acg_top_bench;
    import acg_pkg::*;
    logic i_clk, i_arst_n, i_sfr_wr, i_sfr_rd, i_core_xbus_req, i_core_xbus_internal, i_core_xsp_req;
    logic i_extended_data_ram_int_en, i_capture_dest_ext, i_capture_done, o_ext_port_grant, o_int_extended_data_ram_grant, o_xsp_grant;
    logic o_conv_irq, o_capture_en, o_ext_ref_en, o_cal_busy, o_cal_is_device;
    logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, rd;
    logic [13:0] i_cal_result, o_offset_coef, o_gain_coef;
    logic [3:0] o_channel_sel;
    int n_mismatch = 0;
    int checks = 0;
    acg_top i_acg_top (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
        .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .i_core_xbus_req(i_core_xbus_req),
        .i_core_xbus_internal(i_core_xbus_internal), .i_core_xsp_req(i_core_xsp_req), .i_extended_data_ram_int_en(i_extended_data_ram_int_en),
        .i_capture_dest_ext(i_capture_dest_ext), .i_capture_done(i_capture_done), .i_cal_result(i_cal_result),
        .o_ext_port_grant(o_ext_port_grant), .o_int_extended_data_ram_grant(o_int_extended_data_ram_grant), .o_xsp_grant(o_xsp_grant),
        .o_conv_irq(o_conv_irq), .o_capture_en(o_capture_en), .o_ext_ref_en(o_ext_ref_en),
        .o_channel_sel(o_channel_sel), .o_offset_coef(o_offset_coef), .o_gain_coef(o_gain_coef),
        .o_cal_busy(o_cal_busy), .o_cal_is_device(o_cal_is_device));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and shared tasks
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict;
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Bus cycles leave one idle cycle after each strobe so no strobe is set twice at one edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_sfr_addr = a;
        i_sfr_wdata = d;
        i_sfr_wr = 1'b1;
        @(negedge i_clk);
        i_sfr_wr = 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(negedge i_clk);
        i_sfr_addr = a;
        i_sfr_rd = 1'b1;
        @(negedge i_clk);
        i_sfr_rd = 1'b0;
        rd = o_sfr_rdata;
    endtask
    task automatic grant(input logic [4:0] req, input logic [2:0] exp, input string nm);
        @(negedge i_clk);
        {i_core_xbus_req, i_core_xbus_internal, i_core_xsp_req, i_extended_data_ram_int_en, i_capture_dest_ext} = req;
        @(negedge i_clk);
        check(nm, 16'({o_ext_port_grant, o_int_extended_data_ram_grant, o_xsp_grant}), 16'(exp));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_coef;
        check("ofs_rst", 16'(o_offset_coef), 16'h2000);
        rdr(ADDR_OFS_HIGH);
        check("ofs_hi_rst", 16'(rd), 16'h0020);
        wr(ADDR_OFS_LOW, 8'hA5);
        wr(ADDR_OFS_HIGH, 8'hFF);
        wr(ADDR_GAIN_LOW, 8'h5A);
        wr(ADDR_GAIN_HIGH, 8'h15);
        @(negedge i_clk);
        check("ofs_word", 16'(o_offset_coef), 16'h3FA5);
        check("gain_word", 16'(o_gain_coef), 16'h155A);
        rdr(ADDR_OFS_HIGH);
        check("ofs_hi_rd", 16'(rd), 16'h003F);
        rdr(8'h80);
        check("unmapped", 16'(rd), 16'h0000);
    endtask
    task automatic t_gate;
        grant(5'b10010, 3'b100, "ext_free");
        wr(ADDR_CONTROL_TWO, 8'h40);
        // Capture output trails its register bit by one cycle
        @(negedge i_clk);
        check("capture_bit", 16'(o_capture_en), 16'h0001);
        grant(5'b10010, 3'b000, "ext_blocked");
        grant(5'b11111, 3'b011, "int_during_capture");
        grant(5'b11110, 3'b000, "int_dest_internal");
        grant(5'b11101, 3'b000, "int_disabled");
        wr(ADDR_CONTROL_TWO, 8'h00);
        grant(5'b11110, 3'b011, "int_no_capture");
        grant(5'b00000, 3'b000, "idle");
    endtask
    task automatic t_irq;
        @(negedge i_clk);
        i_capture_done = 1'b1;
        @(negedge i_clk);
        i_capture_done = 1'b0;
        @(negedge i_clk);
        check("irq_set", 16'(o_conv_irq), 16'h0001);
        rdr(ADDR_CONTROL_TWO);
        check("flag_bit", 16'(rd[IRQ_FLAG_BIT]), 16'h0001);
        wr(ADDR_CONTROL_TWO, 8'h00);
        @(negedge i_clk);
        check("irq_clear", 16'(o_conv_irq), 16'h0000);
    endtask
    // Divide by 16, four acquisition clocks, one average: 14*1*20 ticks of 16 cycles each
    task automatic do_cal(input logic [7:0] ch, input logic [7:0] cal, input logic [13:0] res, input logic dev);
        int n;
        i_cal_result = res;
        wr(ADDR_CONTROL_TWO, ch);
        wr(ADDR_CAL_CONTROL, cal);
        rdr(ADDR_CAL_CONTROL);
        check("busy_bit", 16'(rd[BUSY_BIT]), 16'h0001);
        check("dev_mode", 16'(o_cal_is_device), 16'(dev));
        check("chan_sel", 16'(o_channel_sel), 16'(ch[3:0]));
        n = 3;
        while (o_cal_busy === 1'b1 && n < 6000) begin
            @(negedge i_clk);
            n++;
        end
        // Divider phase at the load adds up to one tick of slack
        check("cal_len", 16'(n >= 4460 && n <= 4500), 16'h0001);
        if (n >= 6000) give_verdict();
        @(negedge i_clk);
        check("cal_word", 16'(cal[CAL_TYPE_BIT] ? o_gain_coef : o_offset_coef), 16'(res));
    endtask
    task automatic t_cal;
        wr(ADDR_CONTROL_ONE, 8'h0C);
        do_cal(8'h0B, 8'h11, 14'h1234, 1'b1);
        check("gain_kept", 16'(o_gain_coef), 16'h155A);
        do_cal(8'h0C, 8'h13, 14'h0567, 1'b1);
        wr(ADDR_CONTROL_ONE, 8'h4C);
        @(negedge i_clk);
        check("ext_ref", 16'(o_ext_ref_en), 16'h0001);
        do_cal(8'h00, 8'h11, 14'h0F0F, 1'b0);
        check("gain_kept2", 16'(o_gain_coef), 16'h0567);
        do_cal(8'h01, 8'h13, 14'h2ABC, 1'b0);
        check("ofs_kept", 16'(o_offset_coef), 16'h0F0F);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {i_arst_n, i_sfr_wr, i_sfr_rd, i_core_xbus_req, i_core_xbus_internal} = '0;
        {i_core_xsp_req, i_extended_data_ram_int_en, i_capture_dest_ext, i_capture_done} = '0;
        i_sfr_addr = 8'h00;
        i_sfr_wdata = 8'h00;
        i_cal_result = 14'h0000;
        repeat (4) @(negedge i_clk);
        i_arst_n = 1'b1;
        t_coef();
        t_gate();
        t_irq();
        t_cal();
        give_verdict();
    end
endmodule
bind acg_top acg_chk i_acg_chk (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_core_xbus_req(i_core_xbus_req),
    .i_core_xbus_internal(i_core_xbus_internal), .i_core_xsp_req(i_core_xsp_req), .i_extended_data_ram_int_en(i_extended_data_ram_int_en),
    .i_capture_dest_ext(i_capture_dest_ext), .i_capture_done(i_capture_done), .i_sfr_wr(i_sfr_wr),
    .i_cal_result(i_cal_result), .o_ext_port_grant(o_ext_port_grant), .o_int_extended_data_ram_grant(o_int_extended_data_ram_grant),
    .o_xsp_grant(o_xsp_grant), .o_conv_irq(o_conv_irq), .o_capture_en(o_capture_en), .o_channel_sel(o_channel_sel),
    .o_offset_coef(o_offset_coef), .o_gain_coef(o_gain_coef), .o_cal_busy(o_cal_busy),
    .o_cal_is_device(o_cal_is_device));
